/* rtl/drc_consts.svh */
`ifndef DRC_CONSTS_SVH
`define DRC_CONSTS_SVH

// Clock rate in kHz, used to turn printed times into cycle counts
`define DRC_CLK_KHZ 40000
// Update spacing the host must keep, in ns, and its cycle count (rounded up)
`define DRC_DACWAIT_NS 2100
`define DRC_DACWAIT_CYC ((`DRC_DACWAIT_NS * `DRC_CLK_KHZ + 999999) / 1000000)
// Quiet time after reset before communication, in ns, and its cycle count
`define DRC_RSTWAIT_NS 10000
`define DRC_RSTWAIT_CYC ((`DRC_RSTWAIT_NS * `DRC_CLK_KHZ + 999999) / 1000000)
// Width of the wait counter, large enough for both counts
`define DRC_CNT_W 9

// Code width and field split into row and column of the string decoder
`define DRC_CODE_W 16
`define DRC_ROW_LSB 8
`define DRC_SIDE_W 8
`define DRC_SIDE_N 256

// Span-select encoding
`define DRC_SPAN_FULL 1'h0
`define DRC_SPAN_NARROW 1'h1
// Fault-response encoding
`define DRC_RESP_LOW 1'h0
`define DRC_RESP_HIGH 1'h1

// Reset value, and the code ends forced on an alarm
`define DRC_CODE_RST 16'h0000
`define DRC_CODE_MIN 16'h0000
`define DRC_CODE_MAX 16'hFFFF

`endif

/* rtl/drc_ctrl.sv */
`timescale 1ns/1ps
`include "drc_consts.svh"

module drc_ctrl (
	input wire logic clock,
	input wire logic rstn,
	input wire logic primary_supply_ge_1v71,
	input wire logic primary_supply_le_1v89,
	input wire logic primary_supply_ge_2v7,
	input wire logic primary_supply_le_5v5,
	input wire logic vdd_ge_1v71,
	input wire logic vdd_le_1v89,
	input wire logic span_select,
	input wire logic clear_state,
	input wire logic clear_state_span_select,
	input wire logic fault_response_setting,
	input wire logic [`DRC_CODE_W-1:0] dac_code,
	input wire logic [`DRC_CODE_W-1:0] clear_code,
	input wire logic code_load,
	output logic ready,
	output logic update_busy,
	output drc_pkg::drc_band_type supply_band,
	output logic range_pair_high,
	output logic span_narrow,
	output logic alarm,
	output drc_pkg::drc_fault_type fault_level,
	output logic [`DRC_CODE_W-1:0] applied_code,
	output logic [`DRC_SIDE_N-1:0] tap_row,
	output logic [`DRC_SIDE_N-1:0] tap_col
);
	import drc_pkg::*;

	localparam logic [`DRC_CNT_W-1:0] DACWAIT_CYC = `DRC_CNT_W'(`DRC_DACWAIT_CYC);
	localparam logic [`DRC_CNT_W-1:0] RSTWAIT_CYC = `DRC_CNT_W'(`DRC_RSTWAIT_CYC);

	drc_tap_if tif ();

	// Comparator pins, two stages each; only the second stage is read
	logic [5:0] cmp_meta_r;
	logic [5:0] cmp_sync_r;
	logic [5:0] cmp_pins;
	assign cmp_pins = {primary_supply_ge_1v71, primary_supply_le_1v89, primary_supply_ge_2v7, primary_supply_le_5v5, vdd_ge_1v71, vdd_le_1v89};

	always_ff @(posedge clock) begin
		if (!rstn) begin
			cmp_meta_r <= 6'h00;
			cmp_sync_r <= 6'h00;
		end else begin
			cmp_meta_r <= cmp_pins;
			cmp_sync_r <= cmp_meta_r;
		end
	end

	logic p_ge_lo;
	logic p_le_lo;
	logic p_ge_hi;
	logic p_le_hi;
	logic v_ge_lo;
	logic v_le_lo;
	assign {p_ge_lo, p_le_lo, p_ge_hi, p_le_hi, v_ge_lo, v_le_lo} = cmp_sync_r;

	// Supply monitor state
	drc_band_type band_r;
	drc_band_type band_nxt;
	logic alarm_r;
	logic alarm_nxt;
	drc_fault_type fault_r;
	drc_fault_type fault_nxt;
	logic span_r;
	logic span_nxt;

	// Band is re-evaluated every cycle, so a supply drift shows in band_r three edges after the pins
	always_comb begin
		band_nxt = DRC_BAND_UNDER;
		if (p_ge_lo && p_le_lo && v_ge_lo && v_le_lo) begin
			band_nxt = DRC_BAND_LOW;
		end else if (p_ge_hi && p_le_hi) begin
			band_nxt = DRC_BAND_HIGH;
		end else if (p_ge_hi && !p_le_hi) begin
			band_nxt = DRC_BAND_OVER;
		end
		// Anything outside both windows, the 1.89-2.7 V gap included, alarms
		alarm_nxt = (band_nxt == DRC_BAND_UNDER) || (band_nxt == DRC_BAND_OVER);
		fault_nxt = DRC_FAULT_NONE;
		if (band_nxt == DRC_BAND_OVER) begin
			fault_nxt = (fault_response_setting == `DRC_RESP_HIGH) ? DRC_FAULT_2V5 : DRC_FAULT_0V3;
		end else if (band_nxt == DRC_BAND_UNDER) begin
			fault_nxt = (fault_response_setting == `DRC_RESP_HIGH) ? DRC_FAULT_1V25 : DRC_FAULT_0V15;
		end
		// Clear state takes its own span bit; fault levels sit at the full span ends
		if (alarm_nxt) begin
			span_nxt = `DRC_SPAN_FULL;
		end else if (clear_state) begin
			span_nxt = clear_state_span_select;
		end else begin
			span_nxt = span_select;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			band_r <= DRC_BAND_UNDER;
			alarm_r <= 1'h1;
			fault_r <= DRC_FAULT_0V15;
			span_r <= `DRC_SPAN_FULL;
		end else begin
			band_r <= band_nxt;
			alarm_r <= alarm_nxt;
			fault_r <= fault_nxt;
			span_r <= span_nxt;
		end
	end

	// Update sequencing and the code handed to the string decoder
	drc_state_type state_r;
	drc_state_type state_nxt;
	logic [`DRC_CNT_W-1:0] cnt_r;
	logic [`DRC_CNT_W-1:0] cnt_nxt;
	logic [`DRC_CODE_W-1:0] code_r;
	logic [`DRC_CODE_W-1:0] code_nxt;
	logic [`DRC_CODE_W-1:0] tap_code;

	// Loads during the hold are dropped; the host owns the spacing
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		code_nxt = code_r;
		unique case (state_r)
			DRC_ST_RSTWAIT: begin
				if (cnt_r == RSTWAIT_CYC - `DRC_CNT_W'(1)) begin
					state_nxt = DRC_ST_IDLE;
					cnt_nxt = `DRC_CNT_W'(0);
				end else begin
					cnt_nxt = cnt_r + `DRC_CNT_W'(1);
				end
			end
			DRC_ST_IDLE: begin
				if (code_load) begin
					code_nxt = dac_code;
					state_nxt = DRC_ST_HOLD;
					cnt_nxt = `DRC_CNT_W'(0);
				end
			end
			DRC_ST_HOLD: begin
				if (cnt_r == DACWAIT_CYC - `DRC_CNT_W'(1)) begin
					state_nxt = DRC_ST_IDLE;
					cnt_nxt = `DRC_CNT_W'(0);
				end else begin
					cnt_nxt = cnt_r + `DRC_CNT_W'(1);
				end
			end
			default: begin
				state_nxt = DRC_ST_RSTWAIT;
				cnt_nxt = `DRC_CNT_W'(0);
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_r <= DRC_ST_RSTWAIT;
			cnt_r <= `DRC_CNT_W'(0);
			code_r <= `DRC_CODE_RST;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			code_r <= code_nxt;
		end
	end

	// Alarm overrides everything, then clear state, then the loaded code
	always_comb begin
		if (alarm_r) begin
			tap_code = (fault_response_setting == `DRC_RESP_HIGH) ? `DRC_CODE_MAX : `DRC_CODE_MIN;
		end else if (clear_state) begin
			tap_code = clear_code;
		end else begin
			tap_code = code_r;
		end
	end

	assign tif.code = tap_code;

	drc_tap_dec u_dec (
		.clock(clock),
		.rstn(rstn),
		.tap(tif.dec)
	);

	// Applied code is registered alongside the decoder so both line up
	logic [`DRC_CODE_W-1:0] applied_r;
	always_ff @(posedge clock) begin
		if (!rstn) begin
			applied_r <= `DRC_CODE_RST;
		end else begin
			applied_r <= tap_code;
		end
	end

	assign ready = (state_r != DRC_ST_RSTWAIT);
	assign update_busy = (state_r != DRC_ST_IDLE);
	assign supply_band = band_r;
	assign range_pair_high = (band_r == DRC_BAND_HIGH) || (band_r == DRC_BAND_OVER);
	assign span_narrow = span_r;
	assign alarm = alarm_r;
	assign fault_level = fault_r;
	assign applied_code = applied_r;
	assign tap_row = tif.row;
	assign tap_col = tif.col;
endmodule

/* rtl/drc_pkg.sv */
package drc_pkg;
	// Sequencing of code updates
	typedef enum logic [2:0] {
		DRC_ST_RSTWAIT = 3'h1,
		DRC_ST_IDLE = 3'h2,
		DRC_ST_HOLD = 3'h4
	} drc_state_type;

	// Supply band found by the monitor
	typedef enum logic [1:0] {
		DRC_BAND_LOW = 2'h0,
		DRC_BAND_HIGH = 2'h1,
		DRC_BAND_UNDER = 2'h2,
		DRC_BAND_OVER = 2'h3
	} drc_band_type;

	// Level forced onto the output on an alarm
	typedef enum logic [2:0] {
		DRC_FAULT_NONE = 3'h0,
		DRC_FAULT_0V15 = 3'h1,
		DRC_FAULT_1V25 = 3'h2,
		DRC_FAULT_0V3 = 3'h3,
		DRC_FAULT_2V5 = 3'h4
	} drc_fault_type;
endpackage

/* rtl/drc_tap_dec.sv */
`timescale 1ns/1ps
`include "drc_consts.svh"

// One-hot row and column select; the switch at their crossing is the only closed one
module drc_tap_dec (
	input wire logic clock,
	input wire logic rstn,
	drc_tap_if.dec tap
);
	import drc_pkg::*;

	logic [`DRC_SIDE_N-1:0] row_r;
	logic [`DRC_SIDE_N-1:0] col_r;
	logic [`DRC_SIDE_N-1:0] row_nxt;
	logic [`DRC_SIDE_N-1:0] col_nxt;

	// Each entry compares its own index against the code halves
	genvar i;
	generate
		for (i = 0; i < `DRC_SIDE_N; i++) begin : g_sel
			assign row_nxt[i] = (tap.code[`DRC_CODE_W-1:`DRC_ROW_LSB] == `DRC_SIDE_W'(i));
			assign col_nxt[i] = (tap.code[`DRC_SIDE_W-1:0] == `DRC_SIDE_W'(i));
		end
	endgenerate

	// Registered so the switches never see decode glitches
	always_ff @(posedge clock) begin
		if (!rstn) begin
			row_r <= `DRC_SIDE_N'h1;
			col_r <= `DRC_SIDE_N'h1;
		end else begin
			row_r <= row_nxt;
			col_r <= col_nxt;
		end
	end

	assign tap.row = row_r;
	assign tap.col = col_r;
endmodule

/* rtl/drc_tap_if.sv */
`timescale 1ns/1ps
`include "drc_consts.svh"

// Code to the string decoder and the selected row and column back
interface drc_tap_if;
	logic [`DRC_CODE_W-1:0] code;
	logic [`DRC_SIDE_N-1:0] row;
	logic [`DRC_SIDE_N-1:0] col;
	modport ctrl (output code, input row, input col);
	modport dec (input code, output row, output col);
endinterface

/* testbench/drc_ctrl_assertions.sv */
`timescale 1ns/1ps
`include "drc_consts.svh"
// Port-level watch on the span, alarm and tap logic
module drc_ctrl_assertions (
	input logic clock,
	input logic rstn,
	input logic code_load,
	input logic clear_state,
	input logic [`DRC_CODE_W-1:0] dac_code,
	input logic update_busy,
	input drc_pkg::drc_band_type supply_band,
	input logic range_pair_high,
	input logic span_narrow,
	input logic alarm,
	input drc_pkg::drc_fault_type fault_level,
	input logic [`DRC_CODE_W-1:0] applied_code,
	input logic [`DRC_SIDE_N-1:0] tap_row,
	input logic [`DRC_SIDE_N-1:0] tap_col
);
	import drc_pkg::*;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// A taken load, then busy for exactly 84 cycles
	sequence taken_s;
		code_load && !update_busy;
	endsequence
	sequence hold_s;
		update_busy ##83 update_busy ##1 !update_busy;
	endsequence
	band_alarm_a: assert property (alarm == supply_band[1]) else $error("alarm vs band");
	pair_band_a: assert property (range_pair_high == supply_band[0]) else $error("pair vs band");
	quiet_fault_a: assert property (!alarm |-> fault_level == DRC_FAULT_NONE) else $error("stray fault");
	over_fault_a: assert property (supply_band == DRC_BAND_OVER |-> fault_level inside {3'h3, 3'h4})
		else $error("over level");
	alarm_span_a: assert property (alarm |-> !span_narrow) else $error("narrow in alarm");
	alarm_code_a: assert property (alarm && $past(alarm) |-> applied_code inside {16'h0000, 16'hFFFF})
		else $error("alarm code");
	one_tap_a: assert property ($onehot(tap_row) && $onehot(tap_col)) else $error("taps");
	tap_code_a: assert property ($stable(applied_code) |-> tap_row[applied_code[15:8]] && tap_col[applied_code[7:0]])
		else $error("tap vs code");
	// Code register takes the load at the taken edge, the output stage one edge later
	load_code_a: assert property (taken_s ##1 (!alarm && !clear_state) |=> applied_code == $past(dac_code, 2))
		else $error("load code");
	load_hold_a: assert property (taken_s |=> hold_s) else $error("busy hold");
endmodule

bind drc_ctrl drc_ctrl_assertions chk (.clock, .rstn, .code_load, .clear_state, .dac_code, .update_busy,
	.supply_band, .range_pair_high, .span_narrow, .alarm, .fault_level, .applied_code, .tap_row, .tap_col);

/* testbench/drc_host.sv */
`timescale 1ns/1ps
`include "drc_consts.svh"
// Host side of the update strobe
module drc_host (
	input logic clock,
	input logic ready,
	output logic code_load,
	output logic [`DRC_CODE_W-1:0] dac_code
);
	logic [7:0] gap_r = 8'hFF;
	initial begin
		code_load = 1'h0;
		dac_code = 16'h5A5A;
	end
	// Cycles since last load; saturates so an idle host never wraps
	always @(posedge clock) begin
		gap_r <= code_load ? 8'h00 : (gap_r == 8'hFF ? gap_r : gap_r + 8'h01);
	end
	// One load; early skips the spacing to provoke a refusal
	task automatic load(input logic [`DRC_CODE_W-1:0] c, input logic early);
		@(posedge clock);
		#2;
		while (!ready || (!early && gap_r < 8'h54)) begin
			@(posedge clock);
			#2;
		end
		code_load = 1'h1;
		dac_code = c;
		@(posedge clock);
		#2;
		code_load = 1'h0;
		dac_code = ~c; // Released bus must not look valid
	endtask
endmodule

/* testbench/tb_dac_range_supply_alarm_ctrl.sv */
`timescale 1ns/1ps
`include "drc_consts.svh"
module tb_dac_range_supply_alarm_ctrl;
	import drc_pkg::*;
	logic clock = 1'h0, rstn = 1'h0, span_select = 1'h0, clear_state = 1'h0;
	logic clear_state_span_select = 1'h0, fault_response_setting = 1'h0, busy_q = 1'h1, rise_q = 1'h0;
	logic code_load, ready, update_busy, range_pair_high, span_narrow, alarm;
	logic [5:0] sup = 6'h2F;
	logic [1:0] eb;
	logic [`DRC_CODE_W-1:0] clear_code = 16'h1234, dac_code, applied_code, e, m;
	logic [`DRC_SIDE_N-1:0] tap_row, tap_col;
	drc_band_type supply_band;
	drc_fault_type fault_level;
	logic [31:0] lfsr_r = 32'h401BACBF;
	logic [7:0] band_tab [6] = '{8'hDC, 8'hD6, 8'h9A, 8'h56, 8'hAB, 8'hBD};
	logic [`DRC_CODE_W-1:0] q[$];
	int failures = 0, checks = 0, cyc = 0, n, i;
	drc_ctrl uut (.clock, .rstn, .primary_supply_ge_1v71(sup[5]), .primary_supply_le_1v89(sup[4]), .primary_supply_ge_2v7(sup[3]),
		.primary_supply_le_5v5(sup[2]), .vdd_ge_1v71(sup[1]), .vdd_le_1v89(sup[0]), .span_select, .clear_state,
		.clear_state_span_select, .fault_response_setting, .dac_code, .clear_code, .code_load, .ready,
		.update_busy, .supply_band, .range_pair_high, .span_narrow, .alarm, .fault_level, .applied_code,
		.tap_row, .tap_col);
	drc_host host (.clock, .ready, .code_load, .dac_code);
	initial forever #12.5 clock = ~clock;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (exp !== got) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Hang guard, well above the expected run
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			summarize();
		end
	end
	// A rise of busy marks a taken load; the code reaches the output one edge later
	always @(negedge clock) begin
		if (rise_q) begin
			m = q.pop_front();
			chk("applied_code", m, applied_code);
			chk("tap_select", 2'h3, {tap_row[m[15:8]], tap_col[m[7:0]]});
		end
		rise_q = rstn && ready && update_busy && !busy_q;
		busy_q = update_busy;
	end
	initial begin
		repeat (10) @(posedge clock);
		#2;
		rstn = 1'h1;
		n = 0;
		while (!ready && n < 1000) begin
			@(posedge clock);
			#2;
			n++;
		end
		chk("ready_delay", 400, n);
		// Every supply band, six edges to clear the synchroniser and tap stage
		for (i = 0; i < 6; i++) begin
			lfsr_r = lfsr(lfsr_r);
			{sup, eb} = band_tab[i];
			fault_response_setting = lfsr_r[0];
			repeat (6) @(posedge clock);
			#2;
			chk("supply_band", eb, supply_band);
			chk("alarm", eb[1], alarm);
			chk("range_pair_high", eb[0], range_pair_high);
			chk("fault_level", eb[1] ? 3'h1 + {1'h0, eb[0], fault_response_setting} : 3'h0, fault_level);
			if (eb[1]) chk("fault_code", {16{fault_response_setting}}, applied_code);
		end
		for (i = 0; i < 8; i++) begin
			lfsr_r = lfsr(lfsr_r);
			{clear_state, clear_state_span_select, span_select} = i[2:0];
			clear_code = lfsr_r[15:0];
			repeat (3) @(posedge clock);
			#2;
			chk("span_narrow", clear_state ? clear_state_span_select : span_select, span_narrow);
			if (clear_state) chk("clear_code", clear_code, applied_code);
		end
		clear_state = 1'h0;
		// Loads at the tightest spacing, then one too early that must be dropped
		for (i = 0; i < 4; i++) begin
			lfsr_r = lfsr(lfsr_r);
			q.push_back(lfsr_r[15:0]);
			host.load(lfsr_r[15:0], 1'h0);
		end
		e = lfsr_r[15:0];
		host.load(~e, 1'h1);
		repeat (3) @(posedge clock);
		#2;
		chk("refused_load", e, applied_code);
		chk("pending_loads", 0, q.size());
		summarize();
	end
endmodule
